// [pto_core.sv]
// pwm and counted pulse train output generator
`timescale 1ns/1ps
`include "pto_defines.svh"
module pto_core
    import pto_pkg::*;
#(
    parameter int WORD_W = `PTO_WORD_W
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              run_mode,
    input  wire logic              mode_sel_train,
    input  wire logic [WORD_W-1:0] pwm_period_word,
    input  wire logic [WORD_W-1:0] pwm_on_time_word,
    input  wire logic [WORD_W-1:0] train_rate_word,
    input  wire logic [WORD_W-1:0] train_pulse_count_word,
    input  wire logic              train_start_set,
    output logic                   train_start_bit,
    output logic                   train_done_flag,
    output logic                   pwm_out,
    output logic                   counted_pulse_output,
    output logic                   train_mode_active
);
    // true when a tick counter has reached its limit
    function automatic logic at_limit(input logic [WORD_W-1:0] cnt, input logic [WORD_W-1:0] lim);
        at_limit = (cnt == lim);
    endfunction

    pto_tick_if tk ();

    pto_tick_div u_div (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .tk       (tk)
    );

    logic        tick;
    assign tick = tk.tick;

    // mode selection and stop-to-run detection
    logic        run_q;
    logic        run_d;
    pto_mode_e   mode_q;
    pto_mode_e   mode_d;
    logic        run_rise;

    assign run_rise = run_mode & ~run_q;

    always_comb begin
        run_d  = run_mode;
        mode_d = mode_q;
        if (run_rise) begin
            mode_d = mode_sel_train ? PTO_MODE_TRAIN : PTO_MODE_PWM;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_q  <= 1'b0;
            mode_q <= PTO_MODE_PWM;
        end else begin
            run_q  <= run_d;
            mode_q <= mode_d;
        end
    end

    // pwm generator
    logic [WORD_W-1:0] pwm_cnt_q;
    logic [WORD_W-1:0] pwm_cnt_d;
    logic [WORD_W-1:0] pwm_per_q;
    logic [WORD_W-1:0] pwm_per_d;
    logic [WORD_W-1:0] pwm_on_q;
    logic [WORD_W-1:0] pwm_on_d;
    logic              pwm_out_q;
    logic              pwm_out_d;
    logic              pwm_en;

    assign pwm_en = (mode_q == PTO_MODE_PWM);

    always_comb begin
        pwm_cnt_d = pwm_cnt_q;
        pwm_per_d = pwm_per_q;
        pwm_on_d  = pwm_on_q;
        if (run_rise) begin
            pwm_cnt_d = '0;
            pwm_per_d = pwm_period_word;
            pwm_on_d  = pwm_on_time_word;
        end else if (tick) begin
            if (at_limit(pwm_cnt_q, pwm_per_q)) begin
                pwm_cnt_d = '0;
                pwm_per_d = pwm_period_word;
                pwm_on_d  = pwm_on_time_word;
            end else begin
                pwm_cnt_d = pwm_cnt_q + 1'b1;
            end
        end
        // unsigned compare keeps words above 32767 as long counts
        pwm_out_d = pwm_en && !run_rise && (pwm_cnt_d <= pwm_on_d);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pwm_cnt_q <= '0;
            pwm_per_q <= `PTO_WORD_RST;
            pwm_on_q  <= `PTO_WORD_RST;
            pwm_out_q <= 1'b0;
        end else begin
            pwm_cnt_q <= pwm_cnt_d;
            pwm_per_q <= pwm_per_d;
            pwm_on_q  <= pwm_on_d;
            pwm_out_q <= pwm_out_d;
        end
    end

    // pulse train generator
    pto_tr_state_e     tr_state_q;
    pto_tr_state_e     tr_state_d;
    logic [WORD_W-1:0] tr_div_q;
    logic [WORD_W-1:0] tr_div_d;
    logic [WORD_W-1:0] tr_rate_q;
    logic [WORD_W-1:0] tr_rate_d;
    logic [WORD_W-1:0] tr_left_q;
    logic [WORD_W-1:0] tr_left_d;
    logic              tr_level_q;
    logic              tr_level_d;
    logic              start_q;
    logic              start_d;
    logic              done_q;
    logic              done_d;
    logic              tr_finish;
    logic              tr_en;

    assign tr_en = (mode_q == PTO_MODE_TRAIN);

    always_comb begin
        tr_state_d = tr_state_q;
        tr_div_d   = tr_div_q;
        tr_rate_d  = tr_rate_q;
        tr_left_d  = tr_left_q;
        tr_level_d = tr_level_q;
        done_d     = done_q;
        tr_finish  = 1'b0;
        case (tr_state_q)
            PTO_TR_IDLE: begin
                tr_level_d = 1'b0;
                // rate word zero means no output
                if (tr_en && start_q && (train_rate_word != '0)) begin
                    done_d = 1'b0;
                    if (train_pulse_count_word == '0) begin
                        tr_finish = 1'b1;
                        done_d    = 1'b1;
                    end else begin
                        tr_state_d = PTO_TR_RUN;
                        tr_rate_d  = train_rate_word;
                        tr_left_d  = train_pulse_count_word;
                        tr_div_d   = '0;
                        tr_level_d = 1'b1;
                    end
                end
            end
            PTO_TR_RUN: begin
                // run_mode falling is ignored here, train carries on
                if (tick) begin
                    if (at_limit(tr_div_q, tr_rate_q)) begin
                        tr_div_d   = '0;
                        tr_level_d = ~tr_level_q;
                        if (tr_level_q) begin
                            tr_left_d = tr_left_q - 1'b1;
                            if (tr_left_q == WORD_W'(1)) begin
                                tr_state_d = PTO_TR_IDLE;
                                tr_finish  = 1'b1;
                                done_d     = 1'b1;
                            end
                        end
                    end else begin
                        tr_div_d = tr_div_q + 1'b1;
                    end
                end
            end
            default: begin
                tr_state_d = PTO_TR_IDLE;
                tr_level_d = 1'b0;
            end
        endcase
        if (run_rise) begin
            tr_state_d = PTO_TR_IDLE;
            tr_level_d = 1'b0;
            tr_finish  = 1'b1;
        end
        // a new start request wins over the hardware clear
        start_d = train_start_set | (start_q & ~tr_finish);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tr_state_q <= PTO_TR_IDLE;
            tr_div_q   <= '0;
            tr_rate_q  <= `PTO_WORD_RST;
            tr_left_q  <= '0;
            tr_level_q <= 1'b0;
            start_q    <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            tr_state_q <= tr_state_d;
            tr_div_q   <= tr_div_d;
            tr_rate_q  <= tr_rate_d;
            tr_left_q  <= tr_left_d;
            tr_level_q <= tr_level_d;
            start_q    <= start_d;
            done_q     <= done_d;
        end
    end

    assign pwm_out              = pwm_out_q;
    assign counted_pulse_output = tr_level_q;
    assign train_start_bit      = start_q;
    assign train_done_flag      = done_q;
    assign train_mode_active    = mode_q[1];
endmodule

// [pto_defines.svh]
// constants for the pwm and pulse train output block
`ifndef PTO_DEFINES_SVH
`define PTO_DEFINES_SVH

`define PTO_REF_KHZ     9840
`define PTO_REF_DIV     8
`define PTO_CLK_KHZ     200000
`define PTO_ACC_STEP    (`PTO_REF_KHZ)
`define PTO_ACC_MOD     (`PTO_REF_DIV * `PTO_CLK_KHZ)
`define PTO_ACC_W       21
`define PTO_WORD_W      16
`define PTO_WORD_RST    16'h0000

`endif

// [pto_pkg.sv]
// types for the pwm and pulse train output block
package pto_pkg;
    typedef enum logic [1:0] {
        PTO_MODE_PWM   = 2'b01,
        PTO_MODE_TRAIN = 2'b10
    } pto_mode_e;

    typedef enum logic [1:0] {
        PTO_TR_IDLE = 2'b01,
        PTO_TR_RUN  = 2'b10
    } pto_tr_state_e;
endpackage

// [pto_tick_if.sv]
// reference tick carrier between divider and core
`timescale 1ns/1ps
interface pto_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// [pto_tick_div.sv]
// fractional divider giving one tick per reference/8 period
`timescale 1ns/1ps
`include "pto_defines.svh"
module pto_tick_div
    import pto_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset_n,
    pto_tick_if.src   tk
);
    logic [`PTO_ACC_W-1:0] acc_q;
    logic [`PTO_ACC_W-1:0] acc_d;
    logic                  tick_q;
    logic                  tick_d;
    logic [`PTO_ACC_W:0]   sum;

    // exact rate: 9840 kHz / (8 * 200000 kHz) of core cycles
    always_comb begin
        sum = {1'b0, acc_q} + (`PTO_ACC_W+1)'(`PTO_ACC_STEP);
        if (sum >= (`PTO_ACC_W+1)'(`PTO_ACC_MOD)) begin
            acc_d  = `PTO_ACC_W'(sum - (`PTO_ACC_W+1)'(`PTO_ACC_MOD));
            tick_d = 1'b1;
        end else begin
            acc_d  = sum[`PTO_ACC_W-1:0];
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule

// [pto_core_properties.sv]
// assertions on the pwm and pulse train output ports
`timescale 1ns/1ps
module pto_core_properties (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run_mode,
    input wire logic train_start_bit,
    input wire logic train_done_flag,
    input wire logic pwm_out,
    input wire logic counted_pulse_output,
    input wire logic train_mode_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_done_up;
        $rose(train_done_flag);
    endsequence
    sequence s_pulse_up;
        $rose(counted_pulse_output);
    endsequence
    a_done_drops_start: assert property (s_done_up |-> !train_start_bit)
        else $error("start bit kept at done");
    a_done_out_low: assert property (s_done_up |-> !counted_pulse_output)
        else $error("output high at done");
    a_start_clears_done: assert property ($fell(train_done_flag) |-> counted_pulse_output)
        else $error("done cleared without train");
    a_done_stands: assert property (train_done_flag && !train_start_bit |=> train_done_flag)
        else $error("done flag lost");
    a_start_fall_cause: assert property ($fell(train_start_bit) |-> train_done_flag || !$past(run_mode, 2))
        else $error("start bit cleared early");
    a_train_level_hold: assert property (s_pulse_up |=> counted_pulse_output[*8])
        else $error("train level too short");
    a_pwm_on_hold: assert property (disable iff (!reset_n || !run_mode) $rose(pwm_out) |=> pwm_out[*8])
        else $error("pwm on phase too short");
    a_pwm_off_train: assert property (train_mode_active |=> !pwm_out && (counted_pulse_output -> train_mode_active))
        else $error("pwm active in train mode");
endmodule
bind pto_core pto_core_properties pto_core_properties_i (
    .core_clk(core_clk), .reset_n(reset_n), .run_mode(run_mode), .train_start_bit(train_start_bit),
    .train_done_flag(train_done_flag), .pwm_out(pwm_out), .counted_pulse_output(counted_pulse_output),
    .train_mode_active(train_mode_active));

// [pto_proc_model.sv]
// processor model writing parameter words and control bits
`timescale 1ns/1ps
module pto_proc_model (
    input  wire logic core_clk,
    output logic        run_mode,
    output logic        mode_sel_train,
    output logic [15:0] per_w,
    output logic [15:0] on_w,
    output logic [15:0] rate_w,
    output logic [15:0] cnt_w,
    output logic        start_set
);
    initial begin
        {run_mode, mode_sel_train, start_set} = 3'b000;
        {per_w, on_w, rate_w, cnt_w} = 64'h0;
    end
    // on word passed in already net of output delta delay
    task automatic set_pwm(input logic [15:0] p, input logic [15:0] o);
        @(posedge core_clk) #1;
        per_w = p;
        on_w = o;
    endtask
    task automatic set_train(input logic [15:0] r, input logic [15:0] c);
        @(posedge core_clk) #1;
        rate_w = r;
        cnt_w = c;
    endtask
    task automatic pulse_start;
        @(posedge core_clk) #1;
        start_set = 1'b1;
        @(posedge core_clk) #1;
        start_set = 1'b0;
    endtask
    task automatic set_run(input logic r, input logic t);
        @(posedge core_clk) #1;
        mode_sel_train = t;
        run_mode = r;
        @(posedge core_clk) #1;
    endtask
endmodule

// [tb_top.sv]
// self-checking testbench of the pwm and pulse train output block
`timescale 1ns/1ps
module tb_top;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        run_mode, mode_sel_train, train_start_set, train_start_bit, train_done_flag;
    logic        pwm_out, counted_pulse_output, train_mode_active;
    logic [15:0] per_w, on_w, rate_w, cnt_w;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          n;
    always #2.5 core_clk = ~core_clk;
    pto_proc_model pto_proc_model_i (.core_clk(core_clk), .run_mode(run_mode), .mode_sel_train(mode_sel_train),
        .per_w(per_w), .on_w(on_w), .rate_w(rate_w), .cnt_w(cnt_w), .start_set(train_start_set));
    pto_core pto_core_i (.core_clk(core_clk), .reset_n(reset_n), .run_mode(run_mode),
        .mode_sel_train(mode_sel_train), .pwm_period_word(per_w), .pwm_on_time_word(on_w),
        .train_rate_word(rate_w), .train_pulse_count_word(cnt_w), .train_start_set(train_start_set),
        .train_start_bit(train_start_bit), .train_done_flag(train_done_flag), .pwm_out(pwm_out),
        .counted_pulse_output(counted_pulse_output), .train_mode_active(train_mode_active));
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected bit at %0t", $time);
        end
    endtask
    task automatic check_near(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            num_errors++;
            $display("unexpected length %0d at %0t", got, $time);
        end
    endtask
    // waits for level lvl, then counts cycles it stays
    task automatic run_len(input bit sel, input logic lvl, output int k);
        k = 0;
        while ((sel ? counted_pulse_output : pwm_out) !== lvl && k < 4000) begin
            @(posedge core_clk) #1;
            k++;
        end
        k = 0;
        while ((sel ? counted_pulse_output : pwm_out) === lvl && k < 4000) begin
            @(posedge core_clk) #1;
            k++;
        end
    endtask
    task automatic t_reset;
        check_bit(counted_pulse_output | train_done_flag | train_start_bit | train_mode_active, 1'b0);
        // zero period and on words give a constant on level
        check_bit(pwm_out, 1'b1);
        repeat (400) @(posedge core_clk);
        #1 check_bit(pwm_out, 1'b1);
    endtask
    task automatic t_pwm;
        int lo;
        pto_proc_model_i.set_pwm(16'h0003, 16'h0001);
        pto_proc_model_i.set_run(1'b1, 1'b0);
        run_len(1'b0, 1'b1, n);
        run_len(1'b0, 1'b0, lo);
        check_near(lo, 325, 2);
        run_len(1'b0, 1'b1, n);
        check_near(n, 325, 2);
        check_near(lo + n, 650, 2);
        // new words written mid off phase wait for the period end
        pto_proc_model_i.set_pwm(16'h0001, 16'h8000);
        run_len(1'b0, 1'b0, n);
        check_near(n, 324, 2);
        repeat (400) @(posedge core_clk);
        #1 check_bit(pwm_out, 1'b1);
    endtask
    task automatic t_train;
        pto_proc_model_i.set_run(1'b0, 1'b1);
        pto_proc_model_i.set_run(1'b1, 1'b1);
        check_bit(train_mode_active, 1'b1);
        check_bit(pwm_out, 1'b0);
        pto_proc_model_i.set_train(16'h0001, 16'h0003);
        pto_proc_model_i.pulse_start();
        #5 check_bit(train_done_flag, 1'b0);
        // first high half starts off the free tick phase: one to two ticks
        for (int i = 0; i < 3; i++) begin
            run_len(1'b1, 1'b1, n);
            check_near(n, (i == 0) ? 244 : 325, (i == 0) ? 82 : 2);
            check_bit(train_done_flag, i == 2);
            if (i == 0) pto_proc_model_i.set_run(1'b0, 1'b1);
            if (i < 2) begin
                run_len(1'b1, 1'b0, n);
                check_near(n, (i == 0) ? 323 : 325, 2);
            end
        end
        check_bit(train_start_bit, 1'b0);
        pto_proc_model_i.set_train(16'h0001, 16'h0001);
        pto_proc_model_i.pulse_start();
        check_bit(train_done_flag, 1'b1);
        #5 check_bit(train_done_flag | ~counted_pulse_output, 1'b0);
        run_len(1'b1, 1'b1, n);
        check_near(n, 244, 82);
        check_bit(train_done_flag & ~train_start_bit, 1'b1);
        pto_proc_model_i.set_run(1'b1, 1'b0);
        check_bit(train_mode_active | pwm_out, 1'b0);
    endtask
    task automatic wrap_up;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 check_bit(pwm_out | counted_pulse_output | train_done_flag | train_start_bit | train_mode_active, 1'b0);
        reset_n = 1'b1;
        @(posedge core_clk) #1;
        t_reset();
        t_pwm();
        t_train();
        wrap_up();
    end
endmodule
